// ### i2ct_pkg.sv
package i2ct_pkg;

    // ==========================================================
    // Bus and register map
    localparam int          AW        = 18;
    localparam int          NREG      = 7;
    localparam logic [15:0] IDX_TX    = 16'h4360;
    localparam logic [15:0] IDX_RX    = 16'h4362;
    localparam logic [15:0] IDX_ADR   = 16'h4364;
    localparam logic [15:0] IDX_CTL   = 16'h4366;
    localparam logic [15:0] IDX_EVT   = 16'h4368;
    localparam logic [15:0] IDX_ACC   = 16'h436a;
    localparam logic [15:0] IDX_IEN   = 16'h436c;
    localparam logic [15:0] REG_IDX [NREG] = '{IDX_TX, IDX_RX, IDX_ADR, IDX_CTL,
                                                IDX_EVT, IDX_ACC, IDX_IEN};
    localparam logic [2:0]  SEL_TX    = 3'h0;
    localparam logic [2:0]  SEL_RX    = 3'h1;
    localparam logic [2:0]  SEL_ADR   = 3'h2;
    localparam logic [2:0]  SEL_CTL   = 3'h3;
    localparam logic [2:0]  SEL_EVT   = 3'h4;
    localparam logic [2:0]  SEL_ACC   = 3'h5;
    localparam logic [2:0]  SEL_IEN   = 3'h6;
    localparam logic [2:0]  SEL_NONE  = 3'h7;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    // ==========================================================
    // Field positions
    localparam int CTL_TXCLR = 8;
    localparam int CTL_EN    = 7;
    localparam int CTL_SRST  = 6;
    localparam int CTL_NAK   = 5;
    localparam int CTL_BUS_RELEASE_REQUEST = 4;
    localparam int CTL_STR   = 3;
    localparam int CTL_NF    = 2;
    localparam int CTL_ASYNC = 1;
    localparam int CTL_ACT   = 0;
    localparam int EVT_BUS_STATE_CHANGED = 7;
    localparam int EVT_XFLOW = 5;
    localparam int EVT_BFR   = 4;
    localparam int EVT_DMS   = 3;
    localparam int EVT_SLEEP_ADDR_HIT = 2;
    localparam int EVT_NAK   = 1;
    localparam int EVT_STOP  = 0;
    localparam int IEN_BUS_STATE_CHANGED = 2;
    localparam int IEN_RX    = 1;
    localparam int IEN_TX    = 0;
    localparam logic [7:0] EVT_W1C = 8'h3f;
    localparam logic [7:0] ZERO8   = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_NS       = 5;
    localparam int BUS_FREE_NS  = 25000;
    localparam int BUS_FREE_CYC = BUS_FREE_NS / CLK_NS;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_ACK, PH_RX, PH_TX, PH_MACK, PH_HOLD, PH_SKIP
    } i2ct_phase_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2ct_pin_in_s;

    typedef struct packed {
        logic scl;
        logic scl_oe_n;
        logic sda;
        logic sda_oe_n;
    } i2ct_pin_out_s;

    function automatic logic [AW-1:0] idx_addr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

// ### i2ct_target.sv
`timescale 1ns/1ps
`default_nettype none

module i2ct_target #(
    parameter int BUS_FREE_CYCLES = i2ct_pkg::BUS_FREE_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // AXI4-Lite write
    input  wire logic [i2ct_pkg::AW-1:0]   awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // AXI4-Lite read
    input  wire logic [i2ct_pkg::AW-1:0]   araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // Serial bus pins
    input  wire i2ct_pkg::i2ct_pin_in_s    pin_in,
    output i2ct_pkg::i2ct_pin_out_s        pin_out,
    // Interrupt
    output logic                           irq
);

    typedef struct packed {
        logic [1:0]           scl_m;
        logic [1:0]           sda_m;
        logic [2:0]           scl_h;
        logic [2:0]           sda_h;
        logic                 scl_f;
        logic                 sda_f;
        i2ct_pkg::i2ct_phase_e ph;
        logic [3:0]           bitn;
        logic [7:0]           shift;
        logic                 drive;
        logic                 hold;
        logic                 dir;
        logic                 sel;
        logic                 busy;
        logic [15:0]          low_cnt;
        logic [7:0]           tx;
        logic [7:0]           rx;
        logic [6:0]           adr;
        logic [8:0]           ctl;
        logic [7:0]           evt;
        logic                 rx_ready;
        logic                 tx_empty;
        logic [2:0]           ien;
        logic                 irq;
        logic                 aw_ok;
        logic                 w_ok;
        logic [i2ct_pkg::AW-1:0] awa;
        logic [15:0]          wd;
        logic [1:0]           ws;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [15:0]          rdata;
        logic [1:0]           rresp;
    } i2ct_state_s;

    i2ct_state_s s;
    i2ct_state_s next_s;

    logic        scl_now;
    logic        sda_now;
    logic        rise;
    logic        fall;
    logic        start_ev;
    logic        stop_ev;
    logic        need;
    logic [2:0]  wsel;
    logic [2:0]  rsel;
    logic [15:0] lm;
    logic [7:0]  nb;

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [2:0] reg_sel(input logic [i2ct_pkg::AW-1:0] a);
        logic [2:0] r;
        r = i2ct_pkg::SEL_NONE;
        for (int i = 0; i < i2ct_pkg::NREG; i++) begin
            if (a == i2ct_pkg::idx_addr(i2ct_pkg::REG_IDX[i])) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Bus handshakes
    assign awready = !s.aw_ok && !s.bvalid;
    assign wready  = !s.w_ok && !s.bvalid;
    assign arready = !s.rvalid;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rresp   = s.rresp;
    assign rdata   = {16'h0000, s.rdata};
    assign irq     = s.irq;
    assign pin_out = '{scl: 1'b0, scl_oe_n: !s.hold, sda: 1'b0, sda_oe_n: !s.drive};

    always_comb begin
        next_s = s;
        next_s.scl_m = {s.scl_m[0], pin_in.scl};
        next_s.sda_m = {s.sda_m[0], pin_in.sda};
        next_s.scl_h = {s.scl_h[1:0], s.scl_m[1]};
        next_s.sda_h = {s.sda_h[1:0], s.sda_m[1]};
        scl_now  = s.ctl[i2ct_pkg::CTL_NF] ? maj3(s.scl_h) : s.scl_h[0];
        sda_now  = s.ctl[i2ct_pkg::CTL_NF] ? maj3(s.sda_h) : s.sda_h[0];
        next_s.scl_f = scl_now;
        next_s.sda_f = sda_now;
        rise     = scl_now && !s.scl_f;
        fall     = !scl_now && s.scl_f;
        start_ev = s.scl_f && scl_now && s.sda_f && !sda_now;
        stop_ev  = s.scl_f && scl_now && !s.sda_f && sda_now;
        need     = s.dir ? s.tx_empty : s.rx_ready;
        nb       = {s.shift[6:0], sda_now};
        wsel     = reg_sel(s.awa);
        rsel     = reg_sel(araddr);
        lm       = {{8{s.ws[1]}}, {8{s.ws[0]}}};

        // ======================================================
        // Register writes
        if (awvalid && awready) begin
            next_s.aw_ok = 1'b1;
            next_s.awa   = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_ok = 1'b1;
            next_s.wd   = wdata[15:0];
            next_s.ws   = wstrb[1:0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_ok && s.w_ok && !s.bvalid) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = (wsel == i2ct_pkg::SEL_NONE) ? i2ct_pkg::RESP_SLV
                                                        : i2ct_pkg::RESP_OKAY;
            case (wsel)
                i2ct_pkg::SEL_TX: begin
                    if (s.ws[0]) begin
                        next_s.tx    = s.wd[7:0];
                        next_s.tx_empty = 1'b0;
                    end
                end
                i2ct_pkg::SEL_ADR: begin
                    if (s.ws[0]) begin
                        next_s.adr = s.wd[6:0];
                    end
                end
                i2ct_pkg::SEL_CTL: begin
                    next_s.ctl = 9'((s.ctl & ~lm[8:0]) | (s.wd[8:0] & lm[8:0]));
                end
                i2ct_pkg::SEL_EVT: begin
                    next_s.evt = s.evt & ~(s.wd[7:0] & lm[7:0] & i2ct_pkg::EVT_W1C);
                end
                i2ct_pkg::SEL_IEN: begin
                    if (s.ws[0]) begin
                        next_s.ien = s.wd[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ======================================================
        // Register reads
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = (rsel == i2ct_pkg::SEL_NONE) ? i2ct_pkg::RESP_SLV
                                                        : i2ct_pkg::RESP_OKAY;
            case (rsel)
                i2ct_pkg::SEL_TX:  next_s.rdata = {i2ct_pkg::ZERO8, s.tx};
                // received byte; read releases receive ready
                i2ct_pkg::SEL_RX: begin
                    next_s.rdata = {i2ct_pkg::ZERO8, s.rx};
                    next_s.rx_ready = 1'b0;
                end
                i2ct_pkg::SEL_ADR: next_s.rdata = {9'h000, s.adr};
                i2ct_pkg::SEL_CTL: next_s.rdata = {7'h00, s.ctl};
                // Transition flag is read-only, so a read consumes it
                i2ct_pkg::SEL_EVT: begin
                    next_s.rdata = {i2ct_pkg::ZERO8, s.evt};
                    next_s.evt[i2ct_pkg::EVT_BUS_STATE_CHANGED] = 1'b0;
                end
                i2ct_pkg::SEL_ACC: next_s.rdata = {11'h000, s.rx_ready, s.tx_empty,
                                                    s.busy, s.sel, s.dir};
                i2ct_pkg::SEL_IEN: next_s.rdata = {13'h0000, s.ien};
                default:           next_s.rdata = 16'h0000;
            endcase
        end

        // ======================================================
        // Serial engine, after register writes so events win
        if (start_ev) begin
            next_s.busy  = 1'b1;
            next_s.ph    = i2ct_pkg::PH_ADDR;
            next_s.bitn  = 4'h0;
            next_s.sel   = 1'b0;
            next_s.drive = 1'b0;
            next_s.hold  = 1'b0;
        end else if (stop_ev) begin
            next_s.busy  = 1'b0;
            next_s.ph    = i2ct_pkg::PH_IDLE;
            next_s.sel   = 1'b0;
            next_s.drive = 1'b0;
            next_s.hold  = 1'b0;
            if (s.sel) begin
                next_s.evt[i2ct_pkg::EVT_STOP] = 1'b1;
            end
        end else begin
            case (s.ph)
                i2ct_pkg::PH_ADDR: begin
                    if (rise) begin
                        next_s.shift = nb;
                        next_s.bitn  = s.bitn + 4'h1;
                        if (s.bitn == 4'h7) begin
                            next_s.ph = i2ct_pkg::PH_SKIP;
                            if (nb[7:1] == s.adr) begin
                                if (s.ctl[i2ct_pkg::CTL_ACT]) begin
                                    next_s.sel = 1'b1;
                                    next_s.dir = nb[0];
                                    next_s.ph  = i2ct_pkg::PH_ACK;
                                end else if (s.ctl[i2ct_pkg::CTL_ASYNC]) begin
                                    next_s.evt[i2ct_pkg::EVT_SLEEP_ADDR_HIT] = 1'b1;
                                end
                            end
                        end
                    end
                end
                i2ct_pkg::PH_ACK: begin
                    if (fall && !s.drive && s.bitn != 4'h0) begin
                        next_s.drive = !s.ctl[i2ct_pkg::CTL_NAK];
                        next_s.bitn  = 4'h0;
                    end else if (fall) begin
                        next_s.drive = 1'b0;
                        next_s.ph    = s.ctl[i2ct_pkg::CTL_NAK] ? i2ct_pkg::PH_SKIP
                                                                : i2ct_pkg::PH_HOLD;
                    end
                end
                i2ct_pkg::PH_HOLD: begin
                    if (s.ctl[i2ct_pkg::CTL_STR] && need) begin
                        next_s.hold = 1'b1;
                    end else begin
                        next_s.hold = 1'b0;
                        next_s.bitn = 4'h0;
                        if (s.dir) begin
                            // underflow when nothing new was written
                            if (s.tx_empty) begin
                                next_s.evt[i2ct_pkg::EVT_XFLOW] = 1'b1;
                            end
                            next_s.shift = s.tx;
                            next_s.tx_empty = 1'b1;
                            next_s.drive = !s.tx[7];
                            next_s.ph    = i2ct_pkg::PH_TX;
                        end else begin
                            next_s.ph = i2ct_pkg::PH_RX;
                        end
                    end
                end
                i2ct_pkg::PH_RX: begin
                    if (rise) begin
                        next_s.shift = nb;
                        next_s.bitn  = s.bitn + 4'h1;
                        if (s.bitn == 4'h7) begin
                            if (s.rx_ready) begin
                                next_s.evt[i2ct_pkg::EVT_XFLOW] = 1'b1;
                            end
                            next_s.rx    = nb;
                            next_s.rx_ready = 1'b1;
                            next_s.ph    = i2ct_pkg::PH_ACK;
                        end
                    end
                end
                i2ct_pkg::PH_TX: begin
                    if (rise) begin
                        next_s.bitn = s.bitn + 4'h1;
                        if (!s.drive && !sda_now) begin
                            next_s.evt[i2ct_pkg::EVT_DMS] = 1'b1;
                        end
                    end else if (fall && s.bitn == 4'h8) begin
                        next_s.drive = 1'b0;
                        next_s.ph    = i2ct_pkg::PH_MACK;
                    end else if (fall) begin
                        next_s.shift = {s.shift[6:0], 1'b0};
                        next_s.drive = !s.shift[6];
                    end
                end
                i2ct_pkg::PH_MACK: begin
                    if (rise) begin
                        next_s.evt[i2ct_pkg::EVT_NAK] = sda_now;
                        if (sda_now) begin
                            next_s.ph = i2ct_pkg::PH_SKIP;
                        end
                    end else if (fall) begin
                        next_s.ph = i2ct_pkg::PH_HOLD;
                    end
                end
                default: begin
                end
            endcase
        end

        // bus-free request after the clock sits low too long
        if (s.ctl[i2ct_pkg::CTL_BUS_RELEASE_REQUEST] && s.busy && !scl_now) begin
            next_s.low_cnt = s.low_cnt + 16'h0001;
            if (s.low_cnt == 16'(BUS_FREE_CYCLES - 1)) begin
                next_s.evt[i2ct_pkg::EVT_BFR] = 1'b1;
                next_s.busy    = 1'b0;
                next_s.sel     = 1'b0;
                next_s.drive   = 1'b0;
                next_s.hold    = 1'b0;
                next_s.ph      = i2ct_pkg::PH_IDLE;
                next_s.low_cnt = 16'h0000;
            end
        end else begin
            next_s.low_cnt = 16'h0000;
        end

        // disabled or soft reset releases the lines
        if (!s.ctl[i2ct_pkg::CTL_EN] || s.ctl[i2ct_pkg::CTL_SRST]) begin
            next_s.ph    = i2ct_pkg::PH_IDLE;
            next_s.drive = 1'b0;
            next_s.hold  = 1'b0;
            next_s.sel   = 1'b0;
            next_s.dir   = 1'b0;
        end
        if (s.ctl[i2ct_pkg::CTL_SRST]) begin
            next_s.busy  = 1'b0;
            next_s.rx_ready = 1'b0;
            next_s.tx_empty = 1'b0;
            next_s.evt   = i2ct_pkg::ZERO8;
        end
        if (next_s.busy != s.busy) begin
            next_s.evt[i2ct_pkg::EVT_BUS_STATE_CHANGED] = 1'b1;
        end
        if (s.ctl[i2ct_pkg::CTL_TXCLR]) begin
            next_s.tx = i2ct_pkg::ZERO8;
        end
        next_s.irq = |({s.evt[i2ct_pkg::EVT_BUS_STATE_CHANGED], s.rx_ready, s.tx_empty} & s.ien);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s     <= '0;
            s.scl_m <= 2'h3;
            s.sda_m <= 2'h3;
            s.scl_h <= 3'h7;
            s.sda_h <= 3'h7;
            s.scl_f <= 1'b1;
            s.sda_f <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_tx_clear_hold: assert property (s.ctl[8] |=> s.tx == 8'h00)
        else $error("tx byte not held clear");
    a_disabled_quiet: assert property (!s.ctl[7] |=> s.drive == 1'b0 && !s.hold)
        else $error("disabled target drives bus");
    a_srst_clears: assert property (s.ctl[6] |=> !s.sel && !s.rx_ready && !s.busy)
        else $error("soft reset left state");
    a_ack_answer: assert property (s.ph == i2ct_pkg::PH_ACK && fall && !s.drive
        && s.bitn != 4'h0 && s.ctl[7] && !s.ctl[6] && !start_ev && !stop_ev
        |=> s.drive == !$past(s.ctl[5]))
        else $error("wrong acknowledge answer");
    a_stretch_gated: assert property (s.hold |-> $past(s.ctl[3]))
        else $error("clock held without stretch");
    a_bus_state_changed_change: assert property ($changed(s.busy) |-> s.evt[7])
        else $error("busy change not flagged");
    a_stop_flag: assert property (stop_ev && s.sel && !s.ctl[6] |=> s.evt[0])
        else $error("stop not flagged");
    a_start_busy: assert property (start_ev && !s.ctl[6] && !s.ctl[4] |=> s.busy)
        else $error("start did not mark busy");
    a_rsvd_zero: assert property (s.rvalid |-> s.rdata[15:9] == 7'h00)
        else $error("reserved bits not zero");
    a_irq_rx: assert property (s.rx_ready && s.ien[1] |=> irq)
        else $error("receive ready interrupt missing");
    a_resp_hold: assert property (s.bvalid && !bready |=> s.bvalid ##0 $stable(s.bresp))
        else $error("write response dropped");

    c_addr_match: cover property (s.ph == i2ct_pkg::PH_ADDR ##1 s.sel);
    c_rx_byte: cover property ($rose(s.rx_ready));
    c_tx_load: cover property (s.ph == i2ct_pkg::PH_HOLD ##1 s.ph == i2ct_pkg::PH_TX);
    c_bus_free: cover property ($rose(s.evt[4]));

endmodule // i2ct_target
`default_nettype wire

// ### i2ct_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Serial bus master, 64 ns clock period, waits out stretching
module i2ct_master_model (
    // Resolved bus levels
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Open-drain drive, low pulls the line
    output var logic  scl_drv,
    output var logic  sda_drv
);
    localparam time Q = 16ns;
    logic s;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic pulse();
        #Q;
        scl_drv = 1'b1;
        wait (scl_in === 1'b1);
        #Q;
        s = sda_in;
        #Q;
        scl_drv = 1'b0;
        #Q;
    endtask
    task automatic start();
        sda_drv = 1'b0;
        #Q;
        scl_drv = 1'b0;
    endtask
    task automatic send(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            pulse();
        end
        sda_drv = 1'b1;
        pulse();
        nak = s;
    endtask
    // master samples while target drives, then answers
    task automatic recv(input logic nak, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = 1'b1;
            pulse();
            b[i] = s;
        end
        sda_drv = nak;
        pulse();
        sda_drv = 1'b1;
    endtask
    // stop framing, no extra clock before it
    task automatic stop();
        sda_drv = 1'b0;
        #Q;
        scl_drv = 1'b1;
        wait (scl_in === 1'b1);
        #Q;
        sda_drv = 1'b1;
        #(4*Q);
    endtask
endmodule // i2ct_master_model
`default_nettype wire

// ### i2c_target_register_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_target_register_interface_tb_top;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        irq, m_scl, m_sda, ack;
    logic [7:0]  b;
    int          errors = 0, tests_run = 0;
    i2ct_pkg::i2ct_pin_in_s  pin_in;
    i2ct_pkg::i2ct_pin_out_s pin_out;
    always #2.5 clk = ~clk;
    // Wired-and with pull-ups
    assign pin_in = '{scl: m_scl & pin_out.scl_oe_n, sda: m_sda & pin_out.sda_oe_n};
    i2ct_target #(.BUS_FREE_CYCLES(20)) dut (.clk(clk), .resetn(resetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
    i2ct_master_model m (.scl_in(pin_in.scl), .sda_in(pin_in.sda), .scl_drv(m_scl),
        .sda_drv(m_sda));
    // ============================================================
    // Bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        @(posedge clk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        @(posedge clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        r = rresp;
        rready <= 1'b0;
        chk(rdata, exp);
    endtask
    task automatic xfer(input logic [7:0] a, input logic nak);
        m.start();
        m.send(a, ack);
        chk({31'h0, ack}, {31'h0, nak});
        if (!nak) begin
            m.send(8'ha5, ack);
            chk({31'h0, ack}, 32'h0);
        end
        m.stop();
    endtask
    task automatic stop_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ============================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < i2ct_pkg::NREG; i++) rchk(i2ct_pkg::REG_IDX[i], 32'h0);
        rchk(16'h436e, 32'h0);
        chk({30'h0, r}, {30'h0, i2ct_pkg::RESP_SLV});
        wr(i2ct_pkg::IDX_TX, 16'hffff);
        rchk(i2ct_pkg::IDX_TX, 32'h00ff);
        wr(i2ct_pkg::IDX_ADR, 16'hffff);
        rchk(i2ct_pkg::IDX_ADR, 32'h007f);
        wr(i2ct_pkg::IDX_CTL, 16'h0100);
        rchk(i2ct_pkg::IDX_TX, 32'h0000);
        wr(i2ct_pkg::IDX_IEN, 16'h0002);
        wr(i2ct_pkg::IDX_ADR, 16'h002a);
        wr(i2ct_pkg::IDX_CTL, 16'h0081);
        xfer(8'h54, 1'b0);
        chk({31'h0, irq}, 32'h1);
        rchk(i2ct_pkg::IDX_ACC, 32'h0010);
        rchk(i2ct_pkg::IDX_RX, 32'h00a5);
        rchk(i2ct_pkg::IDX_EVT, 32'h0081);
        wr(i2ct_pkg::IDX_EVT, 16'h0001);
        rchk(i2ct_pkg::IDX_EVT, 32'h0000);
        chk({31'h0, irq}, 32'h0);
        // Read transfer, master ends it with not-acknowledge
        wr(i2ct_pkg::IDX_TX, 16'h003c);
        m.start();
        m.send(8'h55, ack);
        chk({31'h0, ack}, 32'h0);
        m.recv(1'b1, b);
        chk({24'h0, b}, 32'h003c);
        rchk(i2ct_pkg::IDX_ACC, 32'h000f);
        rchk(i2ct_pkg::IDX_EVT, 32'h0082);
        m.stop();
        xfer(8'h56, 1'b1);
        wr(i2ct_pkg::IDX_CTL, 16'h00a1);
        xfer(8'h54, 1'b1);
        wr(i2ct_pkg::IDX_CTL, 16'h0001);
        xfer(8'h54, 1'b1);
        wr(i2ct_pkg::IDX_CTL, 16'h00c1);
        rchk(i2ct_pkg::IDX_EVT, 32'h0000);
        rchk(i2ct_pkg::IDX_ACC, 32'h0000);
        wr(i2ct_pkg::IDX_CTL, 16'h0082);
        xfer(8'h54, 1'b1);
        rchk(i2ct_pkg::IDX_EVT, 32'h0084);
        // Clock left low past the bus-free limit
        wr(i2ct_pkg::IDX_CTL, 16'h0091);
        m.start();
        repeat (40) @(posedge clk);
        rchk(i2ct_pkg::IDX_EVT, 32'h0094);
        rchk(i2ct_pkg::IDX_ACC, 32'h0000);
        m.stop();
        stop_test();
    end
    // Whole run needs well under this span
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // i2c_target_register_interface_tb_top
`default_nettype wire
